// >>> osc_ctrl_defines.vh
// Register map, field positions and reset values of the oscillator control block
`ifndef OSC_CTRL_DEFINES_VH
`define OSC_CTRL_DEFINES_VH
`define HF_TRIM_INDEX 8'hBF
`define HF_CTRL_INDEX 8'hB2
`define LF_CTRL_INDEX 8'h86
`define EXT_CTRL_INDEX 8'hB1
`define T2_CTRL_INDEX 8'hC8
`define T3_CTRL_INDEX 8'h91
`define STATUS_INDEX 8'hC0
`define HF_DIV_LSB 0
`define HF_SUSPEND_BIT 5
`define HF_ENABLE_BIT 7
`define LF_DIV_LSB 0
`define LF_TRIM_LSB 2
`define LF_ENABLE_BIT 7
`define EXT_FREQ_LSB 0
`define EXT_MODE_LSB 4
`define HF_CTRL_RESET 8'h83
// Factory trim stand-in; the value is arbitrary
`define HF_TRIM_RESET 8'h80
`define LF_CTRL_RESET 8'h00
`define EXT_CTRL_RESET 8'h00
`define HF_DIV_RESET 2'b11
`define EXT_MODE_OFF 3'b000
`define EXT_MODE_CMOS 3'b010
`define EXT_MODE_XTAL 3'b110
`define EXT_MODE_CRYSTAL_OUT_PIN 3'b111
`define LF_BASE_KHZ 80
`define CLK_KHZ 20000
`define LF_HALF_CYCLES ((`CLK_KHZ) / (2 * `LF_BASE_KHZ))
`define HF_HALF_CYCLES 1
`define BRESP_OKAY 2'b00
`define BRESP_SLVERR 2'b10
`endif

// >>> oscillator_clock_control.v
// Oscillator control: internal HF and LF oscillators, suspend/wake, timer capture hooks
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "osc_ctrl_defines.vh"
//
// Summary of operation
// RULE1: Reset leaves system clock on HF oscillator
// RULE2: HF post-divide 1/2/4/8, resets to eight
// RULE3: Writing suspend bit 5 halts HF oscillator
// RULE4: Port match or comparator-low events wake
// RULE5: Any wake restarts oscillator, core, peripherals
// RULE6: Core resumes after suspend write, no vector
// RULE7: Software moves clock off PLL before suspend
// RULE8: Software reinitialises PLL after wake
// RULE9: Period trim register resets to factory value
// RULE10: LF oscillator nominal 80 kHz
// RULE11: LF divide 1/2/4/8 by divide field
// RULE12: LF trim at bits 5:2 adjusts frequency
// RULE13: Timer2 falling, timer3 rising LF captures
// RULE14: Capture copies 16-bit count to reload
// RULE15: Crystal mode takes two pins, others one; the code also gives mode 111 both pins and takes none when off
// RULE16: Software picks external type and frequency
module oscillator_clock_control #(
  parameter [7:0] FACTORY_TRIM = `HF_TRIM_RESET,
  parameter integer LF_HALF = `LF_HALF_CYCLES
) (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output wire s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output wire s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output wire s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire [2:0] port_match_i,
  input wire [1:0] cmp_enable_i,
  input wire [1:0] cmp_out_i,
  input wire [15:0] timer2_count_i,
  input wire [15:0] timer3_count_i,
  output reg [15:0] timer2_reload_o,
  output reg [15:0] timer3_reload_o,
  output reg timer2_capture_o,
  output reg timer3_capture_o,
  output reg system_clock_en_o,
  output reg core_run_o,
  output reg wake_o,
  output reg [7:0] hf_trim_o,
  output reg lf_clk_o,
  output reg lf_clk_en_o,
  output reg crystal_in_pin_take_o,
  output reg crystal_out_pin_take_o
);

  // Byte address from a register index (printed offsets are not word aligned)
  function [11:0] idx_addr;
    input [7:0] idx;
    begin
      idx_addr = {2'b00, idx, 2'b00};
    end
  endfunction

  // Divider terminal count for a 2-bit 1/2/4/8 select
  function [2:0] div_last;
    input [1:0] sel;
    begin
      div_last = (3'b001 << sel) - 3'b001;
    end
  endfunction

  reg [7:0] hf_osc_period_trim_r;
  reg [7:0] hf_osc_control_r;
  reg [7:0] lf_osc_control_r;
  reg [7:0] ext_osc_control_r;
  reg t2_capture_mode_r;
  reg t3_capture_mode_r;
  reg suspended_r;
  reg aw_held_r;
  reg w_held_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg [2:0] hf_div_cnt_r;
  reg [2:0] lf_div_cnt_r;
  reg [15:0] lf_base_cnt_r;
  reg lf_prev_r;
  reg [2:0] port_s1_r;
  reg [2:0] port_s2_r;
  reg [2:0] port_s3_r;
  reg [1:0] cmp_s1_r;
  reg [1:0] cmp_s2_r;
  reg [1:0] cmp_s3_r;
  wire [1:0] hf_divide_select;
  wire [1:0] lf_divide_select;
  wire [3:0] lf_freq_trim;
  wire [2:0] ext_mode;
  wire wr_fire;
  wire wake_event;
  wire [15:0] lf_half_trimmed;
  wire lf_enabled;
  // Write payload from the held copy or straight off the bus
  wire [11:0] wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr_i;
  wire [7:0] wr_data = w_held_r ? wdata_r[7:0] : s_axi_wdata_i[7:0];
  wire wr_lane0 = w_held_r ? wstrb_r[0] : s_axi_wstrb_i[0];

  assign hf_divide_select = hf_osc_control_r[`HF_DIV_LSB +: 2];
  assign lf_divide_select = lf_osc_control_r[`LF_DIV_LSB +: 2];
  assign lf_freq_trim = lf_osc_control_r[`LF_TRIM_LSB +: 4];
  assign ext_mode = ext_osc_control_r[`EXT_MODE_LSB +: 3];
  assign lf_enabled = lf_osc_control_r[`LF_ENABLE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshakes; one write and one read at a time
  assign s_axi_awready_o = ~aw_held_r & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_held_r & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;
  assign wr_fire = (aw_held_r | (s_axi_awvalid_i & s_axi_awready_o)) &
                   (w_held_r | (s_axi_wvalid_i & s_axi_wready_o));

  // Wake sources: match events or enabled comparator reading low
  assign wake_event = (|(port_s2_r & port_s3_r)) |
                      (|(cmp_s2_r & cmp_s3_r & cmp_enable_i)) ; // RULE4

  // Half-period terminal count; trim 8 is nominal, a tiny LF_HALF would wrap
  assign lf_half_trimmed = LF_HALF[15:0] + {12'h000, lf_freq_trim} - 16'h0009; // RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Wake inputs arrive from other domains: three-stage sync, act on agreement
  // Comparator stages carry inverted output so that "low" is a high level
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      port_s1_r <= 3'b000;
      port_s2_r <= 3'b000;
      port_s3_r <= 3'b000;
      cmp_s1_r <= 2'b00;
      cmp_s2_r <= 2'b00;
      cmp_s3_r <= 2'b00;
    end else begin
      port_s1_r <= port_match_i;
      port_s2_r <= port_s1_r;
      port_s3_r <= port_s2_r;
      cmp_s1_r <= ~cmp_out_i;
      cmp_s2_r <= cmp_s1_r;
      cmp_s3_r <= cmp_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; address and data accepted in either order
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `BRESP_OKAY;
      hf_osc_period_trim_r <= FACTORY_TRIM; // RULE9
      hf_osc_control_r <= `HF_CTRL_RESET; // RULE1
      lf_osc_control_r <= `LF_CTRL_RESET;
      ext_osc_control_r <= `EXT_CTRL_RESET;
      t2_capture_mode_r <= 1'b0;
      t3_capture_mode_r <= 1'b0;
      suspended_r <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= 1'b0;
      if (s_axi_awvalid_i && s_axi_awready_o && !wr_fire) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o && !wr_fire) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata_i;
        wstrb_r <= s_axi_wstrb_i;
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      // Suspend ends on any wake, interrupt enable plays no part
      if (suspended_r && wake_event) begin
        suspended_r <= 1'b0; // RULE5
        wake_o <= 1'b1;
        hf_osc_control_r[`HF_SUSPEND_BIT] <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= `BRESP_OKAY;
        // Only the low byte lane carries data
        if (!wr_lane0) begin
          s_axi_bresp_o <= `BRESP_OKAY;
        end else if (wr_addr == idx_addr(`HF_TRIM_INDEX)) begin
          hf_osc_period_trim_r <= wr_data; // RULE9
        end else if (wr_addr == idx_addr(`HF_CTRL_INDEX)) begin
          hf_osc_control_r <= wr_data; // RULE2
          if (wr_data[`HF_SUSPEND_BIT]) begin
            suspended_r <= 1'b1; // RULE3
          end
        end else if (wr_addr == idx_addr(`LF_CTRL_INDEX)) begin
          lf_osc_control_r <= wr_data; // RULE11
        end else if (wr_addr == idx_addr(`EXT_CTRL_INDEX)) begin
          ext_osc_control_r <= wr_data;
        end else if (wr_addr == idx_addr(`T2_CTRL_INDEX)) begin
          t2_capture_mode_r <= wr_data[0];
        end else if (wr_addr == idx_addr(`T3_CTRL_INDEX)) begin
          t3_capture_mode_r <= wr_data[0];
        end else if (wr_addr != idx_addr(`STATUS_INDEX)) begin
          s_axi_bresp_o <= `BRESP_SLVERR;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `BRESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `BRESP_OKAY;
      s_axi_rdata_o <= 32'h0000_0000;
      case (s_axi_araddr_i)
        idx_addr(`HF_TRIM_INDEX): s_axi_rdata_o[7:0] <= hf_osc_period_trim_r;
        idx_addr(`HF_CTRL_INDEX): s_axi_rdata_o[7:0] <= hf_osc_control_r;
        idx_addr(`LF_CTRL_INDEX): s_axi_rdata_o[7:0] <= lf_osc_control_r;
        idx_addr(`EXT_CTRL_INDEX): s_axi_rdata_o[7:0] <= ext_osc_control_r;
        idx_addr(`T2_CTRL_INDEX): s_axi_rdata_o[0] <= t2_capture_mode_r;
        idx_addr(`T3_CTRL_INDEX): s_axi_rdata_o[0] <= t3_capture_mode_r;
        idx_addr(`STATUS_INDEX): s_axi_rdata_o[3:0] <= {crystal_in_pin_take_o,
          crystal_out_pin_take_o, lf_clk_o, suspended_r};
        default: s_axi_rresp_o <= `BRESP_SLVERR;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // HF post-divider; enable pulse stands for the system clock, halted in suspend
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      hf_div_cnt_r <= 3'b000;
      system_clock_en_o <= 1'b0;
      core_run_o <= 1'b0;
      hf_trim_o <= FACTORY_TRIM;
    end else begin
      hf_trim_o <= hf_osc_period_trim_r;
      // Core only holds while halted, so it resumes where it stopped
      core_run_o <= ~suspended_r; // RULE6
      if (suspended_r) begin
        system_clock_en_o <= 1'b0; // RULE3
      end else if (hf_div_cnt_r >= div_last(hf_divide_select)) begin
        hf_div_cnt_r <= 3'b000;
        system_clock_en_o <= 1'b1; // RULE2
      end else begin
        hf_div_cnt_r <= hf_div_cnt_r + 3'b001;
        system_clock_en_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LF base near 80 kHz; divider counts base half periods so output stays square
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      lf_base_cnt_r <= 16'h0000;
      lf_div_cnt_r <= 3'b000;
      lf_clk_o <= 1'b0;
      lf_clk_en_o <= 1'b0;
      lf_prev_r <= 1'b0;
    end else begin
      lf_clk_en_o <= 1'b0;
      lf_prev_r <= lf_clk_o;
      if (!lf_enabled) begin
        lf_base_cnt_r <= 16'h0000;
      end else if (lf_base_cnt_r >= lf_half_trimmed) begin
        lf_base_cnt_r <= 16'h0000; // RULE10
        // Pulse marks each rising edge of the divided output
        if (lf_div_cnt_r >= div_last(lf_divide_select)) begin
          lf_div_cnt_r <= 3'b000;
          lf_clk_o <= ~lf_clk_o; // RULE11
          lf_clk_en_o <= ~lf_clk_o;
        end else begin
          lf_div_cnt_r <= lf_div_cnt_r + 3'b001;
        end
      end else begin
        lf_base_cnt_r <= lf_base_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LF edge capture into timer reload registers
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      timer2_reload_o <= 16'h0000;
      timer3_reload_o <= 16'h0000;
      timer2_capture_o <= 1'b0;
      timer3_capture_o <= 1'b0;
    end else begin
      timer2_capture_o <= t2_capture_mode_r & lf_prev_r & ~lf_clk_o; // RULE13
      timer3_capture_o <= t3_capture_mode_r & ~lf_prev_r & lf_clk_o; // RULE13
      if (t2_capture_mode_r && lf_prev_r && !lf_clk_o) begin
        timer2_reload_o <= timer2_count_i; // RULE14
      end
      if (t3_capture_mode_r && !lf_prev_r && lf_clk_o) begin
        timer3_reload_o <= timer3_count_i; // RULE14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin takeover by external oscillator mode
  always @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      crystal_in_pin_take_o <= 1'b0;
      crystal_out_pin_take_o <= 1'b0;
    end else begin
      crystal_in_pin_take_o <= (ext_mode == `EXT_MODE_XTAL) |
                               (ext_mode == `EXT_MODE_CRYSTAL_OUT_PIN); // RULE15
      crystal_out_pin_take_o <= (ext_mode != `EXT_MODE_OFF); // RULE15
    end
  end

endmodule

// >>> osc_ctrl_assertions.sv
// Port checker for the oscillator control block
`timescale 1ns/100ps
module osc_ctrl_assertions (
  input wire sys_clk_i,
  input wire resetn_i,
  input wire s_axi_awready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arvalid_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire [15:0] timer2_count_i,
  input wire [15:0] timer2_reload_o,
  input wire timer2_capture_o,
  input wire timer3_capture_o,
  input wire lf_clk_o,
  input wire system_clock_en_o,
  input wire core_run_o,
  input wire wake_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // Wake takes two steps: the pulse, then the core runs
  sequence s_wake;
    wake_o ##1 core_run_o;
  endsequence
  a_bresp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("bvalid dropped early");
  a_aw_refused: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("write taken during response");
  a_ar_refused: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken during response");
  a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  a_boot_clock: assert property ($rose(resetn_i) |-> ##[1:10] system_clock_en_o)
    else $error("no clock after reset");
  a_t2_falling: assert property (timer2_capture_o |->
    $past(lf_clk_o, 2) && !$past(lf_clk_o))
    else $error("timer2 capture off falling edge");
  a_t3_rising: assert property (timer3_capture_o |->
    !$past(lf_clk_o, 2) && $past(lf_clk_o))
    else $error("timer3 capture off rising edge");
  a_reload_copy: assert property (timer2_capture_o |->
    timer2_reload_o == $past(timer2_count_i))
    else $error("reload not the count");
  a_suspend_stop: assert property (!core_run_o |-> !system_clock_en_o)
    else $error("clock runs while suspended");
  a_wake_resume: assert property (wake_o |-> s_wake)
    else $error("core idle after wake");
endmodule
bind oscillator_clock_control osc_ctrl_assertions u_chk (.sys_clk_i(sys_clk_i),
  .resetn_i(resetn_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
  .s_axi_bready_i(s_axi_bready_i), .s_axi_arvalid_i(s_axi_arvalid_i),
  .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
  .timer2_count_i(timer2_count_i), .timer2_reload_o(timer2_reload_o),
  .timer2_capture_o(timer2_capture_o), .timer3_capture_o(timer3_capture_o),
  .lf_clk_o(lf_clk_o), .system_clock_en_o(system_clock_en_o), .core_run_o(core_run_o),
  .wake_o(wake_o));

// >>> timer_count_model.sv
// Free-running timer counts seen by the capture hooks
`timescale 1ns/100ps
module timer_count_model (
  input wire sys_clk_i,
  input wire resetn_i,
  output logic [15:0] timer2_count_o,
  output logic [15:0] timer3_count_o
);
  // Distinct offset so a swapped capture path shows up
  always @(posedge sys_clk_i) begin
    timer2_count_o <= resetn_i ? timer2_count_o + 16'h0001 : 16'h0000;
  end
  assign timer3_count_o = timer2_count_o + 16'h1000;
endmodule

// >>> tb.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/100ps
`include "osc_ctrl_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, b); end end
module tb;
  localparam [7:0] TRIM = 8'h3C; // arbitrary trim
  logic sys_clk_i, resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  logic s_axi_arready_o, s_axi_rvalid_o, timer2_capture_o, timer3_capture_o, system_clock_en_o;
  logic core_run_o, wake_o, lf_clk_o, lf_clk_en_o, crystal_in_pin_take_o, crystal_out_pin_take_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, cmp_enable_i, cmp_out_i, r;
  logic [2:0] port_match_i;
  logic [15:0] timer2_count_i, timer3_count_i, timer2_reload_o, timer3_reload_o;
  logic [7:0] hf_trim_o, d;
  int n_mismatch, n_tests, i, n, k;
  oscillator_clock_control #(.FACTORY_TRIM(TRIM), .LF_HALF(4)) u_oscillator_clock_control (
    .sys_clk_i, .resetn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .port_match_i,
    .cmp_enable_i, .cmp_out_i, .timer2_count_i, .timer3_count_i, .timer2_reload_o,
    .timer3_reload_o, .timer2_capture_o, .timer3_capture_o, .system_clock_en_o, .core_run_o,
    .wake_o, .hf_trim_o, .lf_clk_o, .lf_clk_en_o, .crystal_in_pin_take_o,
    .crystal_out_pin_take_o);
  timer_count_model u_timer_count_model (.sys_clk_i, .resetn_i,
    .timer2_count_o(timer2_count_i), .timer3_count_o(timer3_count_i));
  initial begin
    sys_clk_i = 0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus tasks; ready is read right after the edge, before any update lands
  task wr(input [7:0] idx, input [7:0] v, output [1:0] rs);
    s_axi_awaddr_i <= {2'b00, idx, 2'b00};
    s_axi_wdata_i <= {24'h00_0000, v};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    rs = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    // Idle edge so a following call never re-raises in this time step
    @(posedge sys_clk_i);
  endtask
  task rd(input [7:0] idx, output [7:0] v, output [1:0] rs);
    s_axi_araddr_i <= {2'b00, idx, 2'b00};
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    {v, rs} = {s_axi_rdata_o[7:0], s_axi_rresp_o};
    s_axi_rready_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  // Spacing of two pulses: 0 system clock enable, 1 LF enable, 2 timer2 capture
  function logic pk(input int s);
    pk = s == 0 ? system_clock_en_o : s == 1 ? lf_clk_en_o : timer2_capture_o;
  endfunction
  task gap(input int s, output int g);
    repeat (12) @(posedge sys_clk_i);
    for (k = 0; k < 500 && pk(s) !== 1'b1; k++) @(posedge sys_clk_i);
    g = 0;
    do begin @(posedge sys_clk_i); g++; end while (pk(s) !== 1'b1 && g < 500);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, port_match_i} = 5'h00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 56'h0;
    s_axi_wstrb_i = 4'hF;
    cmp_enable_i = 2'b11;
    cmp_out_i = 2'b11;
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    rd(`HF_TRIM_INDEX, d, r); `CHK(d, TRIM)
    rd(`HF_CTRL_INDEX, d, r); `CHK(d, `HF_CTRL_RESET)
    gap(0, n); `CHK(n, 8)
    for (i = 0; i < 4; i++) begin
      wr(`HF_CTRL_INDEX, 8'h80 | i[7:0], r);
      gap(0, n); `CHK(n, 1 << i)
    end
    wr(`HF_TRIM_INDEX, 8'h5A, r); `CHK(hf_trim_o, 8'h5A)
    rd(8'h00, d, r); `CHK(r, `BRESP_SLVERR)
    wr(8'h00, 8'h00, r); `CHK(r, `BRESP_SLVERR)
    $display("test registers done");
    // Each wake source in turn; enabled comparators held high must not wake
    for (i = 0; i < 5; i++) begin
      wr(`HF_CTRL_INDEX, 8'hA0, r);
      repeat (20) @(posedge sys_clk_i);
      `CHK(core_run_o, 1'b0)
      if (i < 3) port_match_i <= 3'b001 << i;
      else cmp_out_i <= ~(2'b01 << (i - 3));
      for (n = 0; n < 20 && core_run_o !== 1'b1; n++) @(posedge sys_clk_i);
      `CHK(core_run_o, 1'b1)
      port_match_i <= 3'b000;
      cmp_out_i <= 2'b11;
      repeat (6) @(posedge sys_clk_i);
      rd(`HF_CTRL_INDEX, d, r); `CHK(d[5], 1'b0)
    end
    $display("test suspend done");
    for (i = 0; i < 4; i++) begin
      wr(`LF_CTRL_INDEX, 8'hA0 | i[7:0], r);
      gap(1, n); `CHK(n, 8 << i)
    end
    wr(`LF_CTRL_INDEX, 8'hB0, r);
    gap(1, n); `CHK(n, 16)
    wr(`LF_CTRL_INDEX, 8'hA0, r);
    wr(`T2_CTRL_INDEX, 8'h01, r);
    wr(`T3_CTRL_INDEX, 8'h01, r);
    gap(2, n); `CHK(n, 8)
    `CHK(timer2_reload_o, timer2_count_i - 16'h0001)
    for (n = 0; n < 40 && timer3_capture_o !== 1'b1; n++) @(posedge sys_clk_i);
    `CHK(timer3_reload_o, timer3_count_i - 16'h0001)
    $display("test lf done");
    for (i = 0; i < 4; i++) begin
      d = {1'b0, i == 0 ? 3'b000 : i == 1 ? `EXT_MODE_CMOS : i == 2 ? `EXT_MODE_XTAL :
        `EXT_MODE_CRYSTAL_OUT_PIN, 4'h3};
      wr(`EXT_CTRL_INDEX, d, r);
      repeat (2) @(posedge sys_clk_i);
      `CHK({crystal_in_pin_take_o, crystal_out_pin_take_o},
        i == 0 ? 2'b00 : i == 1 ? 2'b01 : 2'b11)
    end
    $display("test ext done");
    test_done;
  end
  // Watchdog at 40000 cycles, well past the expected run of under a thousand cycles
  initial begin
    #2000000;
    n_mismatch++;
    test_done;
  end
endmodule
